// *** shared/atrs_regs.vh ***
`ifndef ATRS_REGS_VH
`define ATRS_REGS_VH

// register byte offsets
`define ATRS_OFF_CONTROL_A 8'hB0
`define ATRS_OFF_COUNTER 8'hB2
`define ATRS_OFF_COMPARE_A 8'hB3
`define ATRS_OFF_ASYNC_STATUS 8'hB6
`define ATRS_OFF_IRQ_FLAGS 8'hB7
`define ATRS_OFF_IRQ_ENABLE 8'hB8

// async_clock_status fields
`define ATRS_BIT_EXT_CLOCK_EN 4
`define ATRS_BIT_ASYNC_SELECT 3
`define ATRS_BIT_COUNTER_BUSY 2
`define ATRS_BIT_COMPARE_BUSY 1
`define ATRS_BIT_CONTROL_BUSY 0

// timer_control_a fields
`define ATRS_BIT_FORCE_A 7
`define ATRS_COM_HI 5
`define ATRS_COM_LO 4
`define ATRS_CS_HI 2
`define ATRS_CS_LO 0

// flag and enable fields
`define ATRS_BIT_COMPARE_FLAG 1
`define ATRS_BIT_OVERFLOW_FLAG 0

// reset values
`define ATRS_RST_BYTE 8'h00
`define ATRS_RST_FLAGS 2'h0

// timing counts
`define ATRS_XFER_EDGES 2
`define ATRS_FLAG_SYNC_STAGES 3
`define ATRS_HALT_CYCLES 3'h4
`define ATRS_COUNTER_MAX 8'hFF

`endif

// *** logic/atrs_edge_det.v ***
`timescale 1ns/1ps
`default_nettype none

// rising-edge detector for the timer oscillator input; one cycle late pulse
module atrs_edge_det (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire sig_in,
    output reg rise_out
);

reg prev_q;

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        prev_q <= 1'b0;
        rise_out <= 1'b0;
    end else begin
        prev_q <= sig_in;
        rise_out <= sig_in & ~prev_q;
    end
end

endmodule
`default_nettype wire

// *** logic/atrs_xfer_slot.v ***
`timescale 1ns/1ps
`default_nettype none

`include "atrs_regs.vh"

// temporary register with its own busy flag and two-edge transfer
module atrs_xfer_slot (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire wr_in,
    input wire async_in,
    input wire [7:0] data_in,
    input wire edge_in,
    output reg [7:0] temp_out,
    output reg busy_out,
    output reg load_out
);

reg [1:0] edge_cnt_q;

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        temp_out <= `ATRS_RST_BYTE;
        busy_out <= 1'b0;
        load_out <= 1'b0;
        edge_cnt_q <= 2'h0;
    end else begin
        load_out <= 1'b0;
        if (wr_in) begin
            temp_out <= data_in;
            edge_cnt_q <= 2'h0;
            // a second write while busy restarts the transfer
            if (async_in) begin
                busy_out <= 1'b1;
            end else begin
                busy_out <= 1'b0;
                load_out <= 1'b1;
            end
        end else if (busy_out && edge_in) begin
            if (edge_cnt_q == (`ATRS_XFER_EDGES - 1)) begin
                load_out <= 1'b1;
                busy_out <= 1'b0;
                edge_cnt_q <= 2'h0;
            end else begin
                edge_cnt_q <= edge_cnt_q + 2'h1;
            end
        end
    end
end

endmodule
`default_nettype wire

// *** logic/atrs_core.v ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

`include "atrs_regs.vh"

// How it works
// - counter readable and writable; a counter write blocks the next timer-tick match
// - compare value A compared with counter on each running timer tick; match sets flag and drives output
// - external clock buffer enabled with ext bit and async; crystal only when bit clear
// - async select zero uses system clock, one uses oscillator input edges
// - counter, compare and control contents are left as they are across source changes
// - async writes set the matching busy flag; cleared when destination loads
// - counter read gives timer value; compare and control reads give temporaries
// - async writes go to a temporary, loaded after two oscillator rising edges
// - each of the three registers has its own temporary and transfer
// - in async mode compare is off while counter or compare write pends
// - after wake-up, wake logic rearms at the next oscillator rising edge
// - a wake-up halts the processor four cycles; timer already advanced
// - async counter reads come from a copy refreshed on each oscillator rise
// - async flags reach the processor one timer cycle plus three cycles later
// - compare output changes on the timer tick, not resynchronised
// - register contents need not survive power-down or standby wake-up
// - flags clear on vector acknowledge or on writing a one
module atrs_core (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire timer_osc_in,
    input wire sleep_in,
    input wire [1:0] irq_ack_in,
    output reg [7:0] rdata_out,
    output reg compare_output_a_out,
    output reg compare_match_flag_out,
    output reg overflow_flag_out,
    output reg wake_out,
    output reg cpu_halt_out,
    output reg osc_crystal_en_out,
    output reg ext_clock_buf_en_out
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function flag_next;
    input flag;
    input set;
    input clr;
    begin
        // a hardware set in the clearing cycle wins
        flag_next = set | (flag & ~clr);
    end
endfunction

function [7:0] ctrl_view;
    input [7:0] val;
    begin
        // force strobe always reads as zero
        ctrl_view = val & 8'h7F;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// register state

reg ext_clock_input_en_q;
reg async_clock_select_q;
reg [7:0] counter_value_q;
reg [7:0] compare_value_a_q;
reg [7:0] timer_control_a_q;
reg [7:0] counter_sync_q;
reg [1:0] irq_enable_q;
reg block_match_q;
reg cmp_evt_pend_q;
reg ovf_evt_pend_q;
reg [`ATRS_FLAG_SYNC_STAGES-1:0] cmp_sync_q;
reg [`ATRS_FLAG_SYNC_STAGES-1:0] ovf_sync_q;
reg wake_armed_q;
reg [2:0] halt_cnt_q;

wire osc_rise;
wire [7:0] cnt_temp;
wire [7:0] cmp_temp;
wire [7:0] ctl_temp;
wire counter_update_busy;
wire compare_update_busy;
wire control_update_busy;
wire cnt_load;
wire cmp_load;
wire ctl_load;

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire wr_counter = wr_in && (addr_in == `ATRS_OFF_COUNTER);
wire wr_compare = wr_in && (addr_in == `ATRS_OFF_COMPARE_A);
wire wr_control = wr_in && (addr_in == `ATRS_OFF_CONTROL_A);
wire wr_status = wr_in && (addr_in == `ATRS_OFF_ASYNC_STATUS);
wire wr_flags = wr_in && (addr_in == `ATRS_OFF_IRQ_FLAGS);
wire wr_enable = wr_in && (addr_in == `ATRS_OFF_IRQ_ENABLE);

////////////////////////////////////////////////////////////////////////////////
// oscillator edge and transfer slots

atrs_edge_det u_osc_edge (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .sig_in(timer_osc_in),
    .rise_out(osc_rise)
);

// separate slots keep a counter write from disturbing a pending compare write
atrs_xfer_slot u_slot_counter (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_counter),
    .async_in(async_clock_select_q),
    .data_in(wdata_in),
    .edge_in(osc_rise),
    .temp_out(cnt_temp),
    .busy_out(counter_update_busy),
    .load_out(cnt_load)
);

atrs_xfer_slot u_slot_compare (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_compare),
    .async_in(async_clock_select_q),
    .data_in(wdata_in),
    .edge_in(osc_rise),
    .temp_out(cmp_temp),
    .busy_out(compare_update_busy),
    .load_out(cmp_load)
);

atrs_xfer_slot u_slot_control (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_control),
    .async_in(async_clock_select_q),
    .data_in(wdata_in),
    .edge_in(osc_rise),
    .temp_out(ctl_temp),
    .busy_out(control_update_busy),
    .load_out(ctl_load)
);

////////////////////////////////////////////////////////////////////////////////
// timer tick and compare

// in sync mode every system edge is a tick; prescaling is outside this block
wire timer_tick = async_clock_select_q ? osc_rise : 1'b1;
wire running = |timer_control_a_q[`ATRS_CS_HI:`ATRS_CS_LO];
wire step = timer_tick && running;
wire [1:0] com_a = timer_control_a_q[`ATRS_COM_HI:`ATRS_COM_LO];

wire async_pending = async_clock_select_q &&
    (counter_update_busy || compare_update_busy);
wire match = step && (counter_value_q == compare_value_a_q) &&
    !block_match_q && !async_pending;
wire overflow = step && (counter_value_q == `ATRS_COUNTER_MAX);
wire force_cmp = ctl_load && ctl_temp[`ATRS_BIT_FORCE_A];

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        counter_value_q <= `ATRS_RST_BYTE;
        compare_value_a_q <= `ATRS_RST_BYTE;
        timer_control_a_q <= `ATRS_RST_BYTE;
        block_match_q <= 1'b0;
    end else begin
        // a source change leaves these as they are; no repair is attempted
        if (cnt_load) begin
            counter_value_q <= cnt_temp;
            block_match_q <= 1'b1;
        end else if (step) begin
            counter_value_q <= counter_value_q + 8'h01;
            block_match_q <= 1'b0;
        end
        if (cmp_load) begin
            compare_value_a_q <= cmp_temp;
        end
        if (ctl_load) begin
            timer_control_a_q <= ctrl_view(ctl_temp);
        end
    end
end

// output pin follows the tick directly, no flag synchroniser in the path
always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        compare_output_a_out <= 1'b0;
    end else if (match || force_cmp) begin
        case (com_a)
            2'h1: compare_output_a_out <= ~compare_output_a_out;
            2'h2: compare_output_a_out <= 1'b0;
            2'h3: compare_output_a_out <= 1'b1;
            default: compare_output_a_out <= compare_output_a_out;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// counter read copy

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        counter_sync_q <= `ATRS_RST_BYTE;
    end else if (osc_rise) begin
        // refreshed only on oscillator rises, so stale after power-save wake
        counter_sync_q <= counter_value_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt flags

// async events wait one timer cycle, then cross three system stages
always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        cmp_evt_pend_q <= 1'b0;
        ovf_evt_pend_q <= 1'b0;
        cmp_sync_q <= {`ATRS_FLAG_SYNC_STAGES{1'b0}};
        ovf_sync_q <= {`ATRS_FLAG_SYNC_STAGES{1'b0}};
    end else begin
        cmp_sync_q <= {cmp_sync_q[`ATRS_FLAG_SYNC_STAGES-2:0], 1'b0};
        ovf_sync_q <= {ovf_sync_q[`ATRS_FLAG_SYNC_STAGES-2:0], 1'b0};
        if (async_clock_select_q) begin
            if (osc_rise) begin
                cmp_sync_q[0] <= cmp_evt_pend_q;
                ovf_sync_q[0] <= ovf_evt_pend_q;
                cmp_evt_pend_q <= match;
                ovf_evt_pend_q <= overflow;
            end
        end else begin
            cmp_evt_pend_q <= 1'b0;
            ovf_evt_pend_q <= 1'b0;
        end
    end
end

wire async_mode = async_clock_select_q;
wire cmp_set = async_mode ? cmp_sync_q[`ATRS_FLAG_SYNC_STAGES-1] : match;
wire ovf_set = async_mode ? ovf_sync_q[`ATRS_FLAG_SYNC_STAGES-1] : overflow;
wire cmp_clr = irq_ack_in[`ATRS_BIT_COMPARE_FLAG] ||
    (wr_flags && wdata_in[`ATRS_BIT_COMPARE_FLAG]);
wire ovf_clr = irq_ack_in[`ATRS_BIT_OVERFLOW_FLAG] ||
    (wr_flags && wdata_in[`ATRS_BIT_OVERFLOW_FLAG]);

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        compare_match_flag_out <= 1'b0;
        overflow_flag_out <= 1'b0;
    end else begin
        compare_match_flag_out <= flag_next(compare_match_flag_out, cmp_set, cmp_clr);
        overflow_flag_out <= flag_next(overflow_flag_out, ovf_set, ovf_clr);
    end
end

////////////////////////////////////////////////////////////////////////////////
// wake-up and processor halt

wire irq_pending = (compare_match_flag_out && irq_enable_q[`ATRS_BIT_COMPARE_FLAG]) ||
    (overflow_flag_out && irq_enable_q[`ATRS_BIT_OVERFLOW_FLAG]);

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        wake_out <= 1'b0;
        wake_armed_q <= 1'b1;
        halt_cnt_q <= 3'h0;
        cpu_halt_out <= 1'b0;
    end else begin
        wake_out <= 1'b0;
        if (sleep_in && wake_armed_q && irq_pending) begin
            wake_out <= 1'b1;
            wake_armed_q <= 1'b0;
            halt_cnt_q <= `ATRS_HALT_CYCLES;
            cpu_halt_out <= 1'b1;
        end else begin
            if (osc_rise) begin
                // a re-entry before this edge gets no new wake-up
                wake_armed_q <= 1'b1;
            end
            if (halt_cnt_q != 3'h0) begin
                halt_cnt_q <= halt_cnt_q - 3'h1;
                cpu_halt_out <= (halt_cnt_q != 3'h1);
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock source control and enables

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        ext_clock_input_en_q <= 1'b0;
        async_clock_select_q <= 1'b0;
        irq_enable_q <= `ATRS_RST_FLAGS;
        osc_crystal_en_out <= 1'b0;
        ext_clock_buf_en_out <= 1'b0;
    end else begin
        if (wr_status) begin
            ext_clock_input_en_q <= wdata_in[`ATRS_BIT_EXT_CLOCK_EN];
            async_clock_select_q <= wdata_in[`ATRS_BIT_ASYNC_SELECT];
        end
        if (wr_enable) begin
            irq_enable_q <= wdata_in[1:0];
        end
        osc_crystal_en_out <= async_clock_select_q && !ext_clock_input_en_q;
        ext_clock_buf_en_out <= async_clock_select_q && ext_clock_input_en_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port

wire [7:0] status_view = {3'h0, ext_clock_input_en_q, async_clock_select_q,
    counter_update_busy, compare_update_busy, control_update_busy};
wire [7:0] counter_view = async_clock_select_q ? counter_sync_q : counter_value_q;

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        rdata_out <= `ATRS_RST_BYTE;
    end else if (rd_in) begin
        case (addr_in)
            `ATRS_OFF_COUNTER: rdata_out <= counter_view;
            `ATRS_OFF_COMPARE_A: rdata_out <= cmp_temp;
            `ATRS_OFF_CONTROL_A: rdata_out <= ctrl_view(ctl_temp);
            `ATRS_OFF_ASYNC_STATUS: rdata_out <= status_view;
            `ATRS_OFF_IRQ_FLAGS: rdata_out <= {6'h00, compare_match_flag_out,
                overflow_flag_out};
            `ATRS_OFF_IRQ_ENABLE: rdata_out <= {6'h00, irq_enable_q};
            default: rdata_out <= 8'h00;
        endcase
    end else begin
        rdata_out <= 8'h00;
    end
end

endmodule
`default_nettype wire

// *** dv/atrs_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module atrs_core_asserts (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic timer_osc_in,
    input wire logic sleep_in,
    input wire logic [1:0] irq_ack_in,
    input wire logic [7:0] rdata_out,
    input wire logic compare_output_a_out,
    input wire logic compare_match_flag_out,
    input wire logic overflow_flag_out,
    input wire logic wake_out,
    input wire logic cpu_halt_out,
    input wire logic osc_crystal_en_out,
    input wire logic ext_clock_buf_en_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_halt_run;
        cpu_halt_out [*4] ##1 !cpu_halt_out;
    endsequence
    sequence s_status_wr;
        wr_in && addr_in == 8'hB6;
    endsequence
    chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside its slot");
    chk_unmapped_zero: assert property (rd_in && !(addr_in inside {8'hB0, 8'hB2, 8'hB3,
        8'hB6, 8'hB7, 8'hB8}) |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");
    chk_halt_four: assert property ($rose(cpu_halt_out) |-> s_halt_run)
        else $error("halt not four cycles long");
    chk_wake_cause: assert property (wake_out |-> $past(sleep_in) &&
        $past(compare_match_flag_out || overflow_flag_out))
        else $error("wake without sleep and flag");
    chk_wake_halt: assert property (wake_out |-> ##[0:2] cpu_halt_out)
        else $error("wake did not halt the processor");
    chk_wake_single: assert property (wake_out |=> !wake_out)
        else $error("wake pulse longer than one cycle");
    chk_osc_exclusive: assert property (!(osc_crystal_en_out && ext_clock_buf_en_out))
        else $error("crystal and external buffer both on");
    chk_crystal_sel: assert property (s_status_wr and wdata_in[4:3] == 2'h1
        |-> ##[1:3] osc_crystal_en_out)
        else $error("crystal not started in async mode");
    chk_ext_sel: assert property (s_status_wr and wdata_in[4:3] == 2'h3
        |-> ##[1:3] ext_clock_buf_en_out && !osc_crystal_en_out)
        else $error("external clock buffer not enabled");
    chk_cmp_clear: assert property ($fell(compare_match_flag_out) |-> $past(irq_ack_in[1] ||
        (wr_in && addr_in == 8'hB7 && wdata_in[1])))
        else $error("compare flag cleared without cause");
    chk_ovf_clear: assert property ($fell(overflow_flag_out) |-> $past(irq_ack_in[0] ||
        (wr_in && addr_in == 8'hB7 && wdata_in[0])))
        else $error("overflow flag cleared without cause");
endmodule
`default_nettype wire

// *** dv/atrs_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// slow timer oscillator; stands still when not running, like a stopped crystal
module atrs_osc_model #(
    parameter int HALF_NS = 20
) (
    input wire logic run_in,
    output logic osc_out
);
    initial begin
        osc_out = 1'h0;
        forever begin
            #(HALF_NS);
            if (run_in) begin
                osc_out = ~osc_out;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_in, rst_n_in, wr_in, rd_in, sleep_in, osc_run;
    logic [7:0] addr_in, wdata_in, rv;
    logic [1:0] irq_ack_in;
    wire timer_osc_in, compare_output_a_out, compare_match_flag_out, overflow_flag_out;
    wire wake_out, cpu_halt_out, osc_crystal_en_out, ext_clock_buf_en_out;
    wire [7:0] rdata_out;
    int n_fail, checked, cycles, rises, r0, k, h;
    logic [7:0] offs [7] = '{8'hB0, 8'hB2, 8'hB3, 8'hB6, 8'hB7, 8'hB8, 8'hA0};
    atrs_core dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .timer_osc_in(timer_osc_in),
        .sleep_in(sleep_in), .irq_ack_in(irq_ack_in), .rdata_out(rdata_out),
        .compare_output_a_out(compare_output_a_out),
        .compare_match_flag_out(compare_match_flag_out),
        .overflow_flag_out(overflow_flag_out), .wake_out(wake_out),
        .cpu_halt_out(cpu_halt_out), .osc_crystal_en_out(osc_crystal_en_out),
        .ext_clock_buf_en_out(ext_clock_buf_en_out));
    atrs_osc_model #(.HALF_NS(20)) osc_u (.run_in(osc_run), .osc_out(timer_osc_in));
    initial begin
        clk_sys_in = 1'h0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge timer_osc_in) rises++;
    ////////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t byte got %h want %h", $time, got, exp);
        end
    endtask
    task cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_sys_in);
        wr_in <= 1'h0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_sys_in);
        rd_in <= 1'h0;
        #1 d = rdata_out;
    endtask
    task chk_rd(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rv);
        cmp8(rv, exp);
    endtask
    function logic pick(input int sel);
        case (sel)
            0: return compare_match_flag_out;
            1: return overflow_flag_out;
            default: return wake_out;
        endcase
    endfunction
    // bounded so a dead flag ends as a mismatch, not a hang
    task wait_hi(input int sel);
        k = 0;
        while (pick(sel) !== 1'h1 && k < 600) begin
            @(posedge clk_sys_in);
            #1 k++;
        end
        cmp1(pick(sel), 1'h1);
    endtask
    task wait_idle;
        k = 0;
        rd(8'hB6, rv);
        while ((rv & 8'h07) !== 8'h00 && k < 200) begin
            rd(8'hB6, rv);
            k++;
        end
        // a transfer that never finishes counts as a mismatch
        cmp8(rv & 8'h07, 8'h00);
    endtask
    task ack(input logic [1:0] m);
        @(posedge clk_sys_in);
        irq_ack_in <= m;
        @(posedge clk_sys_in);
        irq_ack_in <= 2'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_in, wr_in, rd_in, sleep_in, irq_ack_in} = '0;
        {addr_in, wdata_in} = '0;
        osc_run = 1'h1;
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        for (int i = 0; i < 7; i++) chk_rd(offs[i], 8'h00);
        wr(8'hB3, 8'h55);
        chk_rd(8'hB3, 8'h55);
        wr(8'hB3, 8'h05);
        wr(8'hB0, 8'h11);
        wait_hi(0);
        cmp1(compare_output_a_out, 1'h1);
        chk_rd(8'hB7, 8'h02);
        wr(8'hB7, 8'h02);
        chk_rd(8'hB7, 8'h00);
        wait_hi(1);
        ack(2'h1);
        @(posedge clk_sys_in);
        #1 cmp1(overflow_flag_out, 1'h0);
        wait_hi(0);
        ack(2'h2);
        wr(8'hB3, 8'h80);
        wr(8'hB2, 8'h80);
        repeat (20) @(posedge clk_sys_in);
        #1 cmp1(compare_match_flag_out, 1'h0);
        wr(8'hB8, 8'h02);
        @(posedge clk_sys_in) sleep_in <= 1'h1;
        wait_hi(2);
        h = 0;
        repeat (8) begin
            if (cpu_halt_out === 1'h1) h++;
            @(posedge clk_sys_in);
            // the woken core leaves sleep, so no second wake restarts the halt
            sleep_in <= 1'h0;
            #1;
        end
        cmp8(8'(h), 8'h04);
        @(posedge clk_sys_in) sleep_in <= 1'h0;
        wr(8'hB8, 8'h00);
        wr(8'hB0, 8'h00);
        wr(8'hB7, 8'h03);
        wr(8'hB6, 8'h10);
        wr(8'hB6, 8'h18);
        repeat (3) @(posedge clk_sys_in);
        #1 cmp1(ext_clock_buf_en_out, 1'h1);
        wr(8'hB6, 8'h1F);
        chk_rd(8'hB6, 8'h18);
        wr(8'hB6, 8'h08);
        repeat (3) @(posedge clk_sys_in);
        #1 cmp1(osc_crystal_en_out, 1'h1);
        wr(8'hB0, 8'h00);
        wait_idle();
        @(negedge timer_osc_in);
        r0 = rises;
        wr(8'hB2, 8'h10);
        wr(8'hB3, 8'h20);
        chk_rd(8'hB6, 8'h0E);
        wait_idle();
        cmp8(8'(rises - r0), 8'h02);
        chk_rd(8'hB3, 8'h20);
        @(posedge timer_osc_in);
        repeat (3) @(posedge clk_sys_in);
        chk_rd(8'hB2, 8'h10);
        wr(8'hB0, 8'h01);
        wait_idle();
        wait_hi(0);
        wr(8'hB3, 8'h44);
        @(posedge clk_sys_in) rst_n_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        chk_rd(8'hB6, 8'h00);
        results();
    end
endmodule
bind atrs_core atrs_core_asserts chk_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .timer_osc_in(timer_osc_in), .sleep_in(sleep_in), .irq_ack_in(irq_ack_in),
    .rdata_out(rdata_out), .compare_output_a_out(compare_output_a_out),
    .compare_match_flag_out(compare_match_flag_out), .overflow_flag_out(overflow_flag_out),
    .wake_out(wake_out), .cpu_halt_out(cpu_halt_out),
    .osc_crystal_en_out(osc_crystal_en_out), .ext_clock_buf_en_out(ext_clock_buf_en_out));
`default_nettype wire
